// [rtl/adcsq_pkg.sv]
// Shared constants, register layouts and state codes for the conversion sequencer
package adcsq_pkg;

  // Bus clock rate and the startup delay of the internal asynchronous clock
  localparam int CLK_MHZ     = 50;
  localparam int STARTUP_NS  = 5000;
  localparam int STARTUP_CYC = (STARTUP_NS * CLK_MHZ + 999) / 1000;

  // Phase lengths held as terminal counts (length minus one), except FIRST_EXTRA_CONV_CLOCK, a plain count of added clocks
  localparam logic [7:0] STARTUP_CNT      = 8'(STARTUP_CYC - 1);
  localparam logic [7:0] FIRST_EXTRA_CONV_CLOCK = 8'h03;
  localparam logic [7:0] SAMPLE_SHORT_CNT = 8'h03;
  localparam logic [7:0] SAMPLE_LONG_CNT  = 8'h17;
  localparam logic [7:0] SAR8_CNT         = 8'h0C;
  localparam logic [7:0] SAR10_CNT        = 8'h0F;
  localparam logic [7:0] XFER_BUS_CNT     = 8'h04;

  // Channel code that disables the converter
  localparam logic [4:0] CHAN_OFF = 5'h1F;

  // Input clock select codes
  localparam logic [1:0] CLKSEL_BUS   = 2'h0;
  localparam logic [1:0] CLKSEL_HALF  = 2'h1;
  localparam logic [1:0] CLKSEL_ALT   = 2'h2;
  localparam logic [1:0] CLKSEL_ASYNC = 2'h3;

  typedef struct packed {
    logic       done_irq_enable;
    logic       continuous_enable;
    logic [4:0] channel_select;
  } adcsq_ctrl1_s;

  typedef struct packed {
    logic trigger_source_select;
    logic compare_enable;
    logic compare_greater_select;
  } adcsq_ctrl2_s;

  typedef struct packed {
    logic       long_sample_select;
    logic       mode_10bit;
    logic [1:0] clock_divide;
    logic [1:0] input_clock_select;
  } adcsq_cfg_s;

  localparam adcsq_ctrl1_s CTRL1_RST = '{1'b0, 1'b0, 5'h1F};
  localparam adcsq_ctrl2_s CTRL2_RST = '{1'b0, 1'b0, 1'b0};
  localparam adcsq_cfg_s   CFG_RST   = '{1'b0, 1'b0, 2'h0, 2'h0};
  localparam logic [1:0]   CVH_RST   = 2'h0;
  localparam logic [7:0]   CVL_RST   = 8'h00;
  localparam logic [7:0]   RESULT_RST = 8'h00;

  // Gray codes along idle, startup, sample, convert, transfer
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_STARTUP = 3'h1,
    ST_SAMPLE  = 3'h3,
    ST_CONVERT = 3'h2,
    ST_XFER    = 3'h6
  } adcsq_state_e;

endpackage

// [rtl/adcsq_clk_div.sv]
// Conversion clock source select and divider producing a one-cycle tick
module adcsq_clk_div
  import adcsq_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic [1:0] src_i,
  input  wire logic [1:0] div_i,
  input  wire logic       alt_clk_i,
  input  wire logic       async_clk_i,
  output logic            tick_o
);

  logic       half_r;
  logic       alt_prev_r;
  logic       async_prev_r;
  logic [2:0] div_cnt_r;
  logic       src_tick;
  logic [2:0] limit;

  // Edge history of the slow sources and the bus halver
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      half_r       <= 1'b0;
      alt_prev_r   <= 1'b0;
      async_prev_r <= 1'b0;
    end
    else
    begin
      half_r       <= ~half_r;
      alt_prev_r   <= alt_clk_i;
      async_prev_r <= async_clk_i;
    end

  // Source pick; halver and edge history stay live while the core waits, but the async clock only runs while the core is active
  always_comb
  begin
    unique case (src_i)
      CLKSEL_BUS:  src_tick = 1'b1;
      CLKSEL_HALF: src_tick = half_r;
      CLKSEL_ALT:  src_tick = alt_clk_i & ~alt_prev_r;
      CLKSEL_ASYNC: src_tick = async_clk_i & ~async_prev_r;
    endcase
    limit = 3'((4'h1 << div_i) - 4'h1);
  end

  // Divider restarts while idle so each conversion begins on a known phase
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      div_cnt_r <= 3'h0;
    else if (!run_i)
      div_cnt_r <= 3'h0;
    else if (src_tick)
      div_cnt_r <= (div_cnt_r == limit) ? 3'h0 : 3'(div_cnt_r + 3'h1);

  assign tick_o = run_i & src_tick & (div_cnt_r == limit);

endmodule

// [rtl/adcsq_compare.sv]
// Result against compare value by adding its two's complement
module adcsq_compare
(
  input  wire logic [9:0] result_i,
  input  wire logic [9:0] compare_i,
  input  wire logic       greater_i,
  output logic            hit_o,
  output logic [9:0]      diff_o
);

  logic [10:0] sum;

  // Carry out means result is at or above the compare value
  assign sum    = 11'({1'b0, result_i} + {1'b0, ~compare_i} + 11'h001);
  assign hit_o  = greater_i ? sum[10] : ~sum[10];
  assign diff_o = sum[9:0];

endmodule

// [rtl/adcsq_core.sv]
// Conversion sequencer: start, abort, timing, compare and result transfer
module adcsq_core
  import adcsq_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         ctrl1_wr_i,
  input  wire adcsq_ctrl1_s ctrl1_data_i,
  input  wire logic         ctrl2_wr_i,
  input  wire adcsq_ctrl2_s ctrl2_data_i,
  input  wire logic         cfg_wr_i,
  input  wire adcsq_cfg_s   cfg_data_i,
  input  wire logic         cvh_wr_i,
  input  wire logic [1:0]   cvh_data_i,
  input  wire logic         cvl_wr_i,
  input  wire logic [7:0]   cvl_data_i,
  input  wire logic         result_high_rd_i,
  input  wire logic         result_low_rd_i,
  input  wire logic         hw_trigger_input_i,
  input  wire logic         stop_mode_i,
  input  wire logic         alternate_clock_i,
  input  wire logic         async_conv_clock_i,
  input  wire logic [9:0]   conv_data_i,
  output logic [4:0]        channel_o,
  output logic              sample_o,
  output logic              active_o,
  output logic              async_clk_enable_o,
  output logic [7:0]        result_high_o,
  output logic [7:0]        result_low_o,
  output logic              conversion_done_flag_o,
  output logic              irq_o
);

  adcsq_ctrl1_s ctrl1_r;
  adcsq_ctrl2_s ctrl2_r;
  adcsq_cfg_s   cfg_r;
  logic [1:0]   cvh_r;
  logic [7:0]   cvl_r;
  adcsq_state_e state_r;
  logic [7:0]   cnt_r;
  logic         first_r;
  logic         trig_prev_r;
  logic         stop_prev_r;
  logic         half_read_r;
  logic         done_r;
  logic [7:0]   res_high_r;
  logic [7:0]   res_low_r;
  logic         tick;
  logic         trig_edge;
  logic         stop_abort;
  logic         mode_abort;
  logic         hw_start;
  logic         sw_restart;
  logic         finish;
  logic         blocked;
  logic         cmp_hit;
  logic         cmp_ok;
  logic         transfer;
  logic         restart;
  logic [9:0]   cmp_diff;
  logic [9:0]   raw_value;
  logic [9:0]   cmp_value;
  logic [7:0]   sample_cnt;
  logic [7:0]   sar_cnt;
  logic         is_async;

  // Register images written by software
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST;
      cfg_r   <= CFG_RST;
      cvh_r   <= CVH_RST;
      cvl_r   <= CVL_RST;
    end
    else
    begin
      if (ctrl1_wr_i)
        ctrl1_r <= ctrl1_data_i;
      if (ctrl2_wr_i)
        ctrl2_r <= ctrl2_data_i;
      if (cfg_wr_i)
        cfg_r <= cfg_data_i;
      if (cvh_wr_i)
        cvh_r <= cvh_data_i;
      if (cvl_wr_i)
        cvl_r <= cvl_data_i;
    end

  // Edge history of trigger and stop request; both pins arrive synchronous
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      trig_prev_r <= 1'b0;
      stop_prev_r <= 1'b0;
    end
    else
    begin
      trig_prev_r <= hw_trigger_input_i;
      stop_prev_r <= stop_mode_i;
    end

  // Start and abort decode
  always_comb
  begin
    is_async   = (cfg_r.input_clock_select == CLKSEL_ASYNC);
    trig_edge  = hw_trigger_input_i & ~trig_prev_r;
    stop_abort = stop_mode_i & ~stop_prev_r & ~is_async;
    mode_abort = ctrl2_wr_i | cfg_wr_i | cvh_wr_i | cvl_wr_i;
    sw_restart = ~ctrl2_r.trigger_source_select & (ctrl1_data_i.channel_select != CHAN_OFF);
    // Busy edges fall through: only the idle state accepts a trigger
    hw_start   = (state_r == ST_IDLE) & trig_edge & ctrl2_r.trigger_source_select
                 & (ctrl1_r.channel_select != CHAN_OFF) & ~(stop_mode_i & ~is_async);
    sample_cnt = cfg_r.long_sample_select ? SAMPLE_LONG_CNT : SAMPLE_SHORT_CNT;
    sar_cnt    = cfg_r.mode_10bit ? SAR10_CNT : SAR8_CNT;
  end

  // Compare operands; 8-bit mode compares the low byte only
  assign raw_value = cfg_r.mode_10bit ? conv_data_i : {2'h0, conv_data_i[7:0]};
  assign cmp_value = cfg_r.mode_10bit ? {cvh_r, cvl_r} : {2'h0, cvl_r};

  adcsq_compare u_compare
  (
    .result_i  (raw_value),
    .compare_i (cmp_value),
    .greater_i (ctrl2_r.compare_greater_select),
    .hit_o     (cmp_hit),
    .diff_o    (cmp_diff)
  );

  adcsq_clk_div u_clk_div
  (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .run_i       (state_r == ST_SAMPLE || state_r == ST_CONVERT),
    .src_i       (cfg_r.input_clock_select),
    .div_i       (cfg_r.clock_divide),
    .alt_clk_i   (alternate_clock_i),
    .async_clk_i (async_conv_clock_i),
    .tick_o      (tick)
  );

  // End of conversion: first ones leave through the bus-cycle transfer phase
  always_comb
  begin
    finish   = ((state_r == ST_CONVERT) & tick & (cnt_r == 8'h00) & ~first_r)
               | ((state_r == ST_XFER) & (cnt_r == 8'h00));
    blocked  = half_read_r & cfg_r.mode_10bit;
    cmp_ok   = ~ctrl2_r.compare_enable | cmp_hit;
    // Any abort in the finishing cycle wins, so the dying result is dropped
    transfer = finish & cmp_ok & ~blocked & ~mode_abort & ~stop_abort & ~ctrl1_wr_i;
    // A blocked transfer retries even in single mode unless compare failed
    restart  = ctrl1_r.continuous_enable | (blocked & cmp_ok);
  end

  // Sequencer; stop entry off the async clock and writes to other registers preempt everything, a trigger edge beats a ctrl1 write; no wait-mode gating
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      first_r <= 1'b0;
    end
    else if (mode_abort | stop_abort)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      first_r <= 1'b0;
    end
    else if ((ctrl1_wr_i & sw_restart) | hw_start)
    begin
      // Launch in the cycle after the write or the edge
      first_r <= 1'b1;
      if (is_async)
      begin
        state_r <= ST_STARTUP;
        cnt_r   <= STARTUP_CNT;
      end
      else
      begin
        state_r <= ST_SAMPLE;
        cnt_r   <= 8'(sample_cnt + FIRST_EXTRA_CONV_CLOCK);
      end
    end
    else if (ctrl1_wr_i)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 8'h00;
      first_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE: state_r <= ST_IDLE;
        ST_STARTUP:
          if (cnt_r == 8'h00)
          begin
            state_r <= ST_SAMPLE;
            cnt_r   <= 8'(sample_cnt + FIRST_EXTRA_CONV_CLOCK);
          end
          else
            cnt_r <= 8'(cnt_r - 8'h01);
        ST_SAMPLE:
          if (tick)
          begin
            if (cnt_r == 8'h00)
            begin
              state_r <= ST_CONVERT;
              cnt_r   <= sar_cnt;
            end
            else
              cnt_r <= 8'(cnt_r - 8'h01);
          end
        ST_CONVERT:
          if (tick)
          begin
            if (cnt_r != 8'h00)
              cnt_r <= 8'(cnt_r - 8'h01);
            else if (first_r)
            begin
              state_r <= ST_XFER;
              cnt_r   <= XFER_BUS_CNT;
            end
          end
        ST_XFER:
          if (cnt_r != 8'h00)
            cnt_r <= 8'(cnt_r - 8'h01);
        default:
          state_r <= ST_IDLE;
      endcase
      // Completion overrides the case: restart short or go idle
      if (finish)
      begin
        first_r <= 1'b0;
        if (restart)
        begin
          state_r <= ST_SAMPLE;
          cnt_r   <= sample_cnt;
        end
        else
        begin
          state_r <= ST_IDLE;
          cnt_r   <= 8'h00;
        end
      end
    end

  // Result registers change only on a clean transfer; aborts leave them
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      res_high_r <= RESULT_RST;
      res_low_r  <= RESULT_RST;
    end
    else if (transfer)
    begin
      if (ctrl2_r.compare_enable)
      begin
        res_high_r <= cfg_r.mode_10bit ? {6'h00, cmp_diff[9:8]} : 8'h00;
        res_low_r  <= cmp_diff[7:0];
      end
      else
      begin
        res_high_r <= cfg_r.mode_10bit ? {6'h00, conv_data_i[9:8]} : 8'h00;
        res_low_r  <= conv_data_i[7:0];
      end
    end

  // Half-read lock: a high byte read in 10-bit mode opens it, low byte read closes it
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      half_read_r <= 1'b0;
    else if (result_high_rd_i & cfg_r.mode_10bit)
      half_read_r <= 1'b1;
    else if (result_low_rd_i)
      half_read_r <= 1'b0;

  // Done flag; a transfer in the clearing cycle wins
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      done_r <= 1'b0;
    else if (transfer)
      done_r <= 1'b1;
    else if (ctrl1_wr_i | result_low_rd_i)
      done_r <= 1'b0;

  // Outputs
  assign channel_o              = ctrl1_r.channel_select;
  assign sample_o               = (state_r == ST_SAMPLE);
  assign active_o               = (state_r != ST_IDLE);
  assign async_clk_enable_o     = active_o & is_async;
  assign result_high_o          = res_high_r;
  assign result_low_o           = res_low_r;
  assign conversion_done_flag_o = done_r;
  assign irq_o                  = done_r & ctrl1_r.done_irq_enable;

  // Checks
  a_sw_start_next: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ctrl1_wr_i & sw_restart & ~mode_abort & ~stop_abort |=> active_o & ~sample_o | sample_o)
    else $error("software write did not start a conversion");
  a_hw_start_next: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    hw_start & ~ctrl1_wr_i & ~mode_abort & ~stop_abort |=> active_o)
    else $error("hardware trigger did not start a conversion");
  a_blocked_discard: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    finish & blocked |=> $stable(res_high_r) && $stable(res_low_r))
    else $error("blocked result overwrote registers");
  a_blocked_retry: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    finish & blocked & cmp_ok & ~ctrl1_wr_i & ~mode_abort & ~stop_abort |=> state_r == ST_SAMPLE)
    else $error("blocked transfer did not restart");
  a_mode_abort_idle: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    mode_abort |=> !active_o)
    else $error("register write did not abort");
  a_stop_abort_idle: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    active_o && stop_abort |=> !active_o && $stable(res_low_r))
    else $error("stop entry did not abort cleanly");
  a_async_startup: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i || mode_abort || stop_abort || ctrl1_wr_i)
    $rose(state_r == ST_STARTUP) |-> (state_r == ST_STARTUP)[*8] ##1 async_clk_enable_o)
    else $error("async startup too short or clock not enabled");
  a_cmp_fail_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    finish & ~cmp_ok |=> !$rose(done_r) && $stable(res_low_r))
    else $error("failed compare changed results or flag");
  a_done_on_xfer: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    transfer |=> done_r ##0 (irq_o == ctrl1_r.done_irq_enable))
    else $error("transfer did not set done flag");
  a_first_time: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i || mode_abort || stop_abort || ctrl1_wr_i)
    $rose(state_r == ST_XFER) |-> (state_r == ST_XFER)[*5] ##1 state_r != ST_XFER)
    else $error("transfer phase not five bus cycles");

  c_single_done: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    transfer & ~ctrl1_r.continuous_enable);
  c_blocked_retry: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    finish & blocked & cmp_ok);
  c_compare_pass: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    transfer & ctrl2_r.compare_enable);
  c_continuous: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
    transfer & ctrl1_r.continuous_enable ##1 state_r == ST_SAMPLE);

endmodule

// [test/adcsq_far_model.sv]
// Far-side model: analog level source plus alternate and asynchronous clock sources
module adcsq_far_model
  import adcsq_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       gen_enable_i,
  input  wire logic [9:0] level_i,
  output logic [9:0]      conv_data_o,
  output logic            alt_clk_o,
  output logic            async_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Analog level settles one bus cycle after the bench moves it
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      conv_data_o <= 10'h000;
    else
      conv_data_o <= level_i;

  // Alternate source runs free at half the bus rate
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      alt_clk_o <= 1'b0;
    else
      alt_clk_o <= ~alt_clk_o;

  // Async generator only runs while the converter enables it, else it is driven low
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      async_clk_o <= 1'b0;
    else
      async_clk_o <= gen_enable_i & ~async_clk_o;
endmodule

// [test/testbench.sv]
// Self-checking bench for the conversion sequencer
module testbench
  import adcsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         c1_wr, c2_wr, cfg_wr, cvh_wr, cvl_wr, rh_rd, rl_rd, trig, stop;
  adcsq_ctrl1_s c1_d;
  adcsq_ctrl2_s c2_d;
  adcsq_cfg_s   cfg_d;
  logic [1:0]   cvh_d;
  logic [7:0]   cvl_d, rh, rl, eh, el;
  logic [9:0]   level, conv, cv;
  logic [10:0]  e;
  logic [4:0]   chan;
  logic         act, smp, aen, flag, irq, alt, asy, gt;
  int           fails, total_checks, n;
  int           seed = 32'h48E49A46;

  always #10 clk = ~clk;

  adcsq_far_model far_u (.core_clk_i(clk), .rst_b_i(rst_b), .gen_enable_i(aen), .level_i(level),
    .conv_data_o(conv), .alt_clk_o(alt), .async_clk_o(asy));

  adcsq_core dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .ctrl1_wr_i(c1_wr), .ctrl1_data_i(c1_d),
    .ctrl2_wr_i(c2_wr), .ctrl2_data_i(c2_d), .cfg_wr_i(cfg_wr), .cfg_data_i(cfg_d), .cvh_wr_i(cvh_wr),
    .cvh_data_i(cvh_d), .cvl_wr_i(cvl_wr), .cvl_data_i(cvl_d), .result_high_rd_i(rh_rd),
    .result_low_rd_i(rl_rd), .hw_trigger_input_i(trig), .stop_mode_i(stop), .alternate_clock_i(alt),
    .async_conv_clock_i(asy), .conv_data_i(conv), .channel_o(chan), .sample_o(smp), .active_o(act),
    .async_clk_enable_o(aen), .result_high_o(rh), .result_low_o(rl), .conversion_done_flag_o(flag),
    .irq_o(irq));

  task automatic finish_test;
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // One strobe: 1 ctrl1, 2 ctrl2, 3 cfg, 4 cvh, 5 cvl, 6 high read, 7 low read
  task automatic wr(input int k, input logic [9:0] d);
    @(posedge clk);
    {c1_wr, c2_wr, cfg_wr, cvh_wr, cvl_wr, rh_rd, rl_rd} <= 7'(8'h80 >> k);
    c1_d <= adcsq_ctrl1_s'(d[6:0]);
    c2_d <= adcsq_ctrl2_s'(d[2:0]);
    cfg_d <= adcsq_cfg_s'(d[5:0]);
    cvh_d <= d[9:8];
    cvl_d <= d[7:0];
    @(posedge clk);
    {c1_wr, c2_wr, cfg_wr, cvh_wr, cvl_wr, rh_rd, rl_rd} <= 7'h00;
    #1;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the done flag; a timeout closes the run
  task automatic wait_flag(input int max, output int cnt);
    cnt = 0;
    while (flag !== 1'b1)
    begin
      cyc(1);
      cnt++;
      if (cnt > max)
      begin
        chk(1'b0, "done flag timeout");
        finish_test();
      end
    end
  endtask

  task automatic res_ok(input string msg);
    chk(rh === eh && rl === el, msg);
  endtask

  // Compare outcome and stored difference worked out independently
  function automatic logic [10:0] cmp_exp(input logic [9:0] r, input logic [9:0] c, input logic g);
    return {g ? (r >= c) : (r < c), 10'(r - c)};
  endfunction

  initial
  begin
    {c1_wr, c2_wr, cfg_wr, cvh_wr, cvl_wr, rh_rd, rl_rd, trig, stop} = 9'h000;
    c1_d = CTRL1_RST;
    c2_d = CTRL2_RST;
    cfg_d = CFG_RST;
    cvh_d = 2'h0;
    cvl_d = 8'h00;
    level = 10'h2A5;
    {eh, el} = 16'h0000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(chan === CHAN_OFF && act === 1'b0 && flag === 1'b0, "reset state");
    res_ok("reset result");
    // Single 8-bit software conversions, short then long sampling; no result reads until done
    for (int ls = 0; ls < 2; ls++)
    begin
      level = 10'($random(seed));
      wr(3, {4'h0, ls[0], 5'h00});
      wr(1, 10'h041);
      chk(act === 1'b1 && smp === 1'b1, "no start after write");
      wait_flag(60, n);
      chk(n >= (ls ? 40 : 20) && n <= (ls ? 48 : 28), "conversion time");
      {eh, el} = {8'h00, level[7:0]};
      res_ok("8-bit result");
      chk(irq === 1'b1, "no interrupt");
      cyc(2);
      chk(act === 1'b0, "single kept running");
    end
    // Continuous 10-bit, then a half-read blocks transfers
    wr(3, 10'h010);
    wr(1, 10'h022);
    wait_flag(60, n);
    {eh, el} = {6'h00, level};
    res_ok("10-bit result");
    chk(irq === 1'b0, "interrupt while disabled");
    wr(7, 10'h000);
    wr(6, 10'h000);
    level = 10'($random(seed));
    cyc(80);
    chk(flag === 1'b0, "flag set while blocked");
    res_ok("blocked result stored");
    chk(act === 1'b1, "no restart after block");
    wr(7, 10'h000);
    wait_flag(60, n);
    chk(n <= 22, "later continuous time");
    {eh, el} = {6'h00, level};
    res_ok("continuous result");
    wr(1, 10'h01F);
    chk(act === 1'b0 && chan === CHAN_OFF, "channel off kept running");
    // Writes to other registers abort a running continuous conversion
    for (int k = 2; k < 6; k++)
    begin
      level = 10'($random(seed));
      wr(1, 10'h023);
      cyc(5);
      wr(k, (k == 3) ? 10'h010 : 10'h000);
      chk(act === 1'b0, "no abort on write");
      cyc(40);
      res_ok("abort changed results");
    end
    // Control one rewrite restarts timing; stop entry aborts
    wr(1, 10'h023);
    cyc(10);
    wr(1, 10'h023);
    wait_flag(60, n);
    chk(n >= 23, "rewrite did not restart");
    {eh, el} = {6'h00, level};
    res_ok("restart result");
    wr(1, 10'h023);
    cyc(5);
    @(posedge clk);
    stop <= 1'b1;
    cyc(2);
    chk(act === 1'b0, "stop did not abort");
    @(posedge clk);
    stop <= 1'b0;
    // Hardware trigger: write alone idles, rising edge starts, busy edges ignored
    wr(2, 10'h004);
    wr(1, 10'h003);
    chk(act === 1'b0, "started without trigger");
    @(posedge clk);
    trig <= 1'b1;
    cyc(1);
    chk(act === 1'b1, "trigger edge ignored");
    @(posedge clk);
    trig <= 1'b0;
    @(posedge clk);
    trig <= 1'b1;
    wait_flag(60, n);
    res_ok("triggered result");
    cyc(3);
    chk(act === 1'b0, "busy edge restarted");
    @(posedge clk);
    trig <= 1'b0;
    // Compare: forced hit and miss first, then random
    for (int i = 0; i < 8; i++)
    begin
      cv = (i < 2) ? 10'h000 : 10'($random(seed));
      gt = (i < 2) ? (i == 0) : 1'($random(seed));
      level = 10'($random(seed));
      wr(4, cv);
      wr(5, cv);
      wr(2, {8'h00, 1'b1, gt});
      wr(1, 10'h043);
      e = cmp_exp(level, cv, gt);
      if (e[10])
      begin
        wait_flag(60, n);
        {eh, el} = {6'h00, e[9:0]};
        chk(irq === 1'b1, "compare hit no interrupt");
      end
      else
      begin
        cyc(60);
        chk(flag === 1'b0 && act === 1'b0, "compare miss flagged");
      end
      res_ok("compare result");
    end
    // Asynchronous clock: generator enabled while active, startup delay first
    wr(2, 10'h000);
    wr(3, 10'h013);
    wr(1, 10'h003);
    chk(aen === 1'b1, "async clock not enabled");
    cyc(200);
    chk(flag === 1'b0, "startup skipped");
    wait_flag(600, n);
    chk(n >= 78, "startup shorter than five microseconds");
    {eh, el} = {6'h00, level};
    res_ok("async result");
    cyc(2);
    chk(aen === 1'b0, "async clock left on");
    // Reset in mid-conversion clears results
    wr(1, 10'h023);
    cyc(5);
    @(posedge clk);
    rst_b <= 1'b0;
    cyc(2);
    chk(rh === 8'h00 && rl === 8'h00 && chan === CHAN_OFF && act === 1'b0, "reset abort");
    @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    finish_test();
  end
endmodule
